// ---- rtl/bstc_pkg.sv ----
package bstc_pkg;
    // Channel count and register widths
    localparam int CHAN_N = 9;
    localparam int IR_W = 8;
    // Boundary chain lengths: per channel driver input, line output cell, plus enables; config b adds bus_pos and bus_neg cells per channel
    localparam int BSR_A_LEN = 2 * CHAN_N + 2;
    localparam int BSR_B_LEN = 4 * CHAN_N + 2;
    // Fixed capture value of the instruction register
    localparam logic [7:0] IR_CAPTURE = 8'h3d;
    // Opcodes in configuration a
    localparam logic [7:0] OP_A_EXTEST = 8'h00;
    localparam logic [7:0] OP_A_SAMPLE = 8'h82;
    localparam logic [7:0] OP_A_CLAMP = 8'h87;
    // Opcodes in configuration b
    localparam logic [7:0] OP_B_EXTEST = 8'h99;
    localparam logic [7:0] OP_B_SAMPLE = 8'h92;
    localparam logic [7:0] OP_B_CLAMP = 8'h8f;
    // Common opcode
    localparam logic [7:0] OP_HIGHZ = 8'h06;
    // Reset value of the instruction register selects bypass
    localparam logic [7:0] IR_RESET = 8'hff;

    // Decoded instruction
    typedef enum logic [2:0] {
        BSTC_BYPASS, BSTC_EXTEST, BSTC_SAMPLE, BSTC_CLAMP, BSTC_HIGHZ
    } bstc_instr_t;

    // Test access port pins grouped
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } bstc_tap_in_t;

    // Channel pin group of all nine channels
    typedef struct packed {
        logic [CHAN_N-1:0] busPos;
        logic [CHAN_N-1:0] busNeg;
        logic [CHAN_N-1:0] busOe;
    } bstc_bus_out_t;
endpackage : bstc_pkg

// ---- rtl/bstc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Config a chain holds logic-side cells only
// - Config b chain adds bus pin cells
// - Bypass is one stage, captures zero
// - Instruction register eight bits, captures 00111101
// - Config a opcodes for extest, sample, clamp
// - Config b opcodes for extest, sample, clamp
// - 00000110 is highz; others select bypass
// - Driven bus follows input, complement opposite
// - Driver disabled leaves bus high impedance
// - Receiver sign of difference, else high impedance
// - Active-low test reset forces reset state
module bstc_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire bstc_pkg::bstc_tap_in_t tapIn,
    input wire logic scan_config_b,
    input wire logic drive_on,
    input wire logic receive_on_n,
    input wire logic [bstc_pkg::CHAN_N-1:0] dataIn,
    input wire logic [bstc_pkg::CHAN_N-1:0] busDiff,
    output bstc_pkg::bstc_bus_out_t busOut,
    output logic [bstc_pkg::CHAN_N-1:0] line_out,
    output logic [bstc_pkg::CHAN_N-1:0] lineOutOe,
    output logic tdo,
    output logic tdoOe
);
    import bstc_pkg::*;

    // TAP controller states
    typedef enum logic [3:0] {
        S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UP_DR,
        S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UP_IR
    } bstc_tap_t;

    // Decoder used by the instruction update
    function automatic bstc_instr_t decodeOp(input logic [7:0] op, input logic cfgB);
        if (op == OP_HIGHZ) return BSTC_HIGHZ;
        if (!cfgB) begin
            if (op == OP_A_EXTEST) return BSTC_EXTEST;
            if (op == OP_A_SAMPLE) return BSTC_SAMPLE;
            if (op == OP_A_CLAMP) return BSTC_CLAMP;
        end else begin
            if (op == OP_B_EXTEST) return BSTC_EXTEST;
            if (op == OP_B_SAMPLE) return BSTC_SAMPLE;
            if (op == OP_B_CLAMP) return BSTC_CLAMP;
        end
        return BSTC_BYPASS;
    endfunction : decodeOp

    // Three-stage synchronisers for the tester pins
    logic [2:0] tckS_q, tmsS_q, tdiS_q, trstS_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tckS_q <= 3'h0;
            tmsS_q <= 3'h7;
            tdiS_q <= 3'h7;
            trstS_q <= 3'h0;
        end else begin
            tckS_q <= {tckS_q[1:0], tapIn.tck};
            tmsS_q <= {tmsS_q[1:0], tapIn.tms};
            tdiS_q <= {tdiS_q[1:0], tapIn.tdi};
            trstS_q <= {trstS_q[1:0], tapIn.trstN};
        end
    end

    // Filtered levels: a change counts once stages two and three agree
    logic tckF_q, tmsF_q, tdiF_q, trstF_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tckF_q <= 1'b0;
            tmsF_q <= 1'b1;
            tdiF_q <= 1'b1;
            trstF_q <= 1'b0;
        end else begin
            if (tckS_q[1] == tckS_q[2]) tckF_q <= tckS_q[2];
            if (tmsS_q[1] == tmsS_q[2]) tmsF_q <= tmsS_q[2];
            if (tdiS_q[1] == tdiS_q[2]) tdiF_q <= tdiS_q[2];
            if (trstS_q[1] == trstS_q[2]) trstF_q <= trstS_q[2];
        end
    end

    // Test clock edges found in the system clock domain
    logic tckRise, tckFall, tapRst;
    assign tckRise = (tckS_q[1] == tckS_q[2]) && tckS_q[2] && !tckF_q;
    assign tckFall = (tckS_q[1] == tckS_q[2]) && !tckS_q[2] && tckF_q;
    // Test reset works without any test clock edge; latency is the synchroniser plus the filter stage
    assign tapRst = !trstF_q;

    // TAP state machine, advances on test clock rise
    bstc_tap_t tap_q, tap_d;
    always_comb begin
        tap_d = tap_q;
        unique case (tap_q)
            S_RESET: tap_d = tmsF_q ? S_RESET : S_IDLE;
            S_IDLE: tap_d = tmsF_q ? S_SEL_DR : S_IDLE;
            S_SEL_DR: tap_d = tmsF_q ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: tap_d = tmsF_q ? S_EX1_DR : S_SH_DR;
            S_SH_DR: tap_d = tmsF_q ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: tap_d = tmsF_q ? S_UP_DR : S_PA_DR;
            S_PA_DR: tap_d = tmsF_q ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: tap_d = tmsF_q ? S_UP_DR : S_SH_DR;
            S_UP_DR: tap_d = tmsF_q ? S_SEL_DR : S_IDLE;
            S_SEL_IR: tap_d = tmsF_q ? S_RESET : S_CAP_IR;
            S_CAP_IR: tap_d = tmsF_q ? S_EX1_IR : S_SH_IR;
            S_SH_IR: tap_d = tmsF_q ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: tap_d = tmsF_q ? S_UP_IR : S_PA_IR;
            S_PA_IR: tap_d = tmsF_q ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: tap_d = tmsF_q ? S_UP_IR : S_SH_IR;
            S_UP_IR: tap_d = tmsF_q ? S_SEL_DR : S_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!reset_n || tapRst) tap_q <= S_RESET;
        else if (tckRise) tap_q <= tap_d;
    end

    // Instruction shift and active registers
    logic [IR_W-1:0] irSh_q, irAct_q;
    bstc_instr_t instr_q;
    always_ff @(posedge clock) begin
        if (!reset_n || tapRst || (tap_q == S_RESET && tckRise)) begin
            irSh_q <= IR_RESET;
            irAct_q <= IR_RESET;
            instr_q <= BSTC_BYPASS;
        end else if (tckRise) begin
            if (tap_q == S_CAP_IR) irSh_q <= IR_CAPTURE;
            else if (tap_q == S_SH_IR) irSh_q <= {tdiF_q, irSh_q[IR_W-1:1]};
            if (tap_q == S_UP_IR) begin
                irAct_q <= irSh_q;
                instr_q <= decodeOp(irSh_q, scan_config_b);
            end
        end
    end

    // Bypass stage
    logic bypass_q;
    always_ff @(posedge clock) begin
        if (!reset_n) bypass_q <= 1'b0;
        else if (tckRise && tap_q == S_CAP_DR) bypass_q <= 1'b0;
        else if (tckRise && tap_q == S_SH_DR) bypass_q <= tdiF_q;
    end

    // Boundary chain, long enough for config b; config a uses the low part
    // Cells: [k]=data in, [9+k]=line out, [18]=drive_on, [19]=receive_on_n,
    // then [20+k]=bus_pos, [29+k]=bus_neg as observed on the bus
    logic [BSR_B_LEN-1:0] bsrSh_q, bsrUp_q;
    logic [BSR_B_LEN-1:0] bsrCap;
    logic [CHAN_N-1:0] rxBit;
    assign rxBit = busDiff;
    assign bsrCap = {~busDiff, busDiff, receive_on_n, drive_on, rxBit, dataIn};
    logic useBsr;
    assign useBsr = (instr_q == BSTC_EXTEST) || (instr_q == BSTC_SAMPLE);
    logic bsrMsbIn;
    // Config a shortens the chain to logic-side cells only
    assign bsrMsbIn = tdiF_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bsrSh_q <= '0;
            bsrUp_q <= '0;
        end else if (tckRise && useBsr) begin
            if (tap_q == S_CAP_DR) bsrSh_q <= bsrCap;
            else if (tap_q == S_SH_DR) begin
                if (scan_config_b) bsrSh_q <= {bsrMsbIn, bsrSh_q[BSR_B_LEN-1:1]};
                else bsrSh_q <= {bsrSh_q[BSR_B_LEN-1:BSR_A_LEN], bsrMsbIn,
                    bsrSh_q[BSR_A_LEN-1:1]};
            end else if (tap_q == S_UP_DR) bsrUp_q <= bsrSh_q;
        end
    end

    // Test data out changes on test clock fall only
    logic tdoBit;
    always_comb begin
        tdoBit = bypass_q;
        if (tap_q == S_SH_IR) tdoBit = irSh_q[0];
        else if (tap_q == S_SH_DR && useBsr) tdoBit = bsrSh_q[0];
    end
    always_ff @(posedge clock) begin
        if (!reset_n || tapRst) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdo <= tdoBit;
            tdoOe <= (tap_q == S_SH_IR) || (tap_q == S_SH_DR);
        end
    end

    // Effective channel controls: normal pins or boundary cells under extest/clamp
    logic testDrive;
    assign testDrive = (instr_q == BSTC_EXTEST) || (instr_q == BSTC_CLAMP);
    logic drvEn, rxEn;
    logic [CHAN_N-1:0] drvData;
    assign drvEn = testDrive ? bsrUp_q[2*CHAN_N] : drive_on;
    assign rxEn = testDrive ? !bsrUp_q[2*CHAN_N+1] : !receive_on_n;
    assign drvData = testDrive ? bsrUp_q[CHAN_N-1:0] : dataIn;
    logic highZ;
    assign highZ = (instr_q == BSTC_HIGHZ);

    // Pin outputs, all registered
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            // Complement starts opposite, so the pair never reads equal
            busOut.busPos <= '0;
            busOut.busNeg <= '1;
            busOut.busOe <= '0;
            line_out <= '0;
            lineOutOe <= '0;
        end else begin
            // Driver: high/high drive only, high/low loopback
            busOut.busOe <= {CHAN_N{drvEn && !highZ}};
            busOut.busPos <= drvData;
            busOut.busNeg <= ~drvData;
            // Receiver: low/low receive only, low/high all off
            lineOutOe <= {CHAN_N{rxEn && !highZ}};
            line_out <= testDrive ? bsrUp_q[2*CHAN_N-1:CHAN_N] : busDiff;
        end
    end

    // Highz floats every bus and line output one clock later
    highz_float_a: assert property (@(posedge clock) disable iff (!reset_n)
        highZ |=> (busOut.busOe == '0 && lineOutOe == '0))
        else $error("highz left an output driven");
    // Disabled driver floats the bus
    drv_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!testDrive && !drive_on) |=> busOut.busOe == '0)
        else $error("bus driven with driver off");
    // Complement pin is opposite
    bus_comp_a: assert property (@(posedge clock) disable iff (!reset_n)
        busOut.busPos == ~busOut.busNeg)
        else $error("bus pins not complementary");
    // Receiver enable follows active low pin
    rx_en_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!testDrive && !highZ && !receive_on_n) |=> lineOutOe == '1)
        else $error("receiver not enabled");

    // Pin checks skip test drive, where update cells own the pins
    // Driven bus follows the logic input of the clock before
    bus_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        !testDrive |=> (busOut.busPos == $past(dataIn) && busOut.busNeg == ~$past(dataIn)))
        else $error("bus pins not following input");
    // Driver enable high turns the driver on
    drv_on_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!testDrive && !highZ && drive_on) |=> busOut.busOe == '1)
        else $error("driver not enabled");
    // Receiver enable high turns the receiver off
    rx_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!testDrive && receive_on_n) |=> lineOutOe == '0)
        else $error("receiver driven while off");
    // Line output carries the bus sign
    rx_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        !testDrive |=> line_out == $past(busDiff))
        else $error("line output not following bus");

    // Port checks pause while test reset holds the controller, except bypass capture and the test reset checks
    // Instruction capture loads pattern
    ir_cap_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckRise && tap_q == S_CAP_IR) |=> irSh_q == IR_CAPTURE)
        else $error("instruction capture wrong");
    // Bypass capture loads zero
    byp_cap_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tckRise && tap_q == S_CAP_DR) |=> !bypass_q)
        else $error("bypass capture not zero");
    // Bypass shift takes test data in
    byp_shift_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckRise && tap_q == S_SH_DR) |=> bypass_q == $past(tdiF_q))
        else $error("bypass shift wrong");
    // Update copies the shifted instruction
    ir_upd_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckRise && tap_q == S_UP_IR) |=> irAct_q == $past(irSh_q))
        else $error("instruction update wrong");
    // Test reset reaches reset state
    trst_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
        tapRst |=> tap_q == S_RESET)
        else $error("test reset ignored");
    // Test reset leaves bypass selected
    trst_bypass_a: assert property (@(posedge clock) disable iff (!reset_n)
        tapRst |=> instr_q == BSTC_BYPASS)
        else $error("test reset kept instruction");
    // Update decodes highz in both configs
    highz_dec_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckRise && tap_q == S_UP_IR && irSh_q == OP_HIGHZ) |=> instr_q == BSTC_HIGHZ)
        else $error("highz not decoded");
    // State only moves on test clock rise
    tap_step_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        !tckRise |=> $stable(tap_q))
        else $error("tap moved without edge");
    // Low select in reset state leads to idle
    idle_enter_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckRise && tap_q == S_RESET && !tmsF_q) |=> tap_q == S_IDLE)
        else $error("reset state did not leave");
    // Test data out moves on test clock fall only
    tdo_hold_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        !tckFall |=> ($stable(tdo) && $stable(tdoOe)))
        else $error("test data out moved without fall");
    // Instruction shift drives its low bit out
    ir_out_a: assert property (@(posedge clock) disable iff (!reset_n || tapRst)
        (tckFall && tap_q == S_SH_IR) |=> (tdoOe && tdo == irSh_q[0]))
        else $error("instruction bit not on test data out");
endmodule : bstc_top

// ---- tb/bstc_tester.sv ----
`timescale 1ns/1ps
// Tester model on the test port; tck stands still between frames
module bstc_tester import bstc_pkg::*; (
    output bstc_tap_in_t tapIn,
    input wire logic tdo
);
    logic [63:0] outQ; // Bits seen on tdo, first bit in bit 0
    event done; // One scan finished
    // Test reset held low from power-up
    initial tapIn = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trstN: 1'b0};
    // One tck cycle: change after the fall, take tdo just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tapIn.tms = m;
        tapIn.tdi = d;
        #62.5 q = tdo;
        tapIn.tck = 1'b1;
        #62.5 tapIn.tck = 1'b0;
    endtask : step
    // Pulse test reset, then walk to idle
    task automatic tap_reset();
        logic q;
        tapIn.trstN = 1'b0;
        #100 tapIn.trstN = 1'b1;
        #100;
        for (int i = 0; i < 6; i++) step(i < 5, tapIn.tdi, q);
    endtask : tap_reset
    // Idle to idle scan of n bits, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din);
        logic q;
        outQ = '0;
        step(1'b1, tapIn.tdi, q);
        if (ir) step(1'b1, tapIn.tdi, q);
        step(1'b0, tapIn.tdi, q);
        step(1'b0, tapIn.tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            outQ[i] = q;
        end
        step(1'b1, tapIn.tdi, q);
        step(1'b0, tapIn.tdi, q);
        // Released data line must not look like a held bit
        #4 tapIn.tdi = ~tapIn.tdi;
        #4 -> done;
        // Let the watcher read outQ before the next scan clears it
        #4;
    endtask : scan
endmodule : bstc_tester

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// Bench: tester model on the test port, channel pins driven here
module tb_top;
    import bstc_pkg::*;
    typedef struct {logic [63:0] m; logic [63:0] e;} bstc_note_t; // Mask and expected bits
    logic clock = 1'b0; // 250 MHz
    logic reset_n = 1'b0;
    logic scan_config_b = 1'b0;
    logic drive_on = 1'b0;
    logic receive_on_n = 1'b1;
    logic [CHAN_N-1:0] dataIn = '0;
    logic [CHAN_N-1:0] busDiff = '0;
    bstc_tap_in_t tapIn;
    bstc_bus_out_t busOut;
    logic [CHAN_N-1:0] line_out;
    logic [CHAN_N-1:0] lineOutOe;
    logic tdo;
    logic tdoOe;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'he92a8797;
    bstc_note_t scanQ[$]; // Expected scan results, oldest first
    bstc_note_t pinQ[$]; // Expected pin states
    event pinTake;
    // Own, sample, clamp, highz, other config extest, unassigned code
    logic [7:0] opTab [2][6] = '{'{OP_A_EXTEST, OP_A_SAMPLE, OP_A_CLAMP, OP_HIGHZ, OP_B_EXTEST, IR_CAPTURE},
        '{OP_B_EXTEST, OP_B_SAMPLE, OP_B_CLAMP, OP_HIGHZ, OP_A_EXTEST, IR_CAPTURE}};

    bstc_top i_dut (.clock(clock), .reset_n(reset_n), .tapIn(tapIn), .scan_config_b(scan_config_b),
        .drive_on(drive_on), .receive_on_n(receive_on_n), .dataIn(dataIn), .busDiff(busDiff),
        .busOut(busOut), .line_out(line_out), .lineOutOe(lineOutOe), .tdo(tdo), .tdoOe(tdoOe));
    // Released test data out reads inverted, so a missing enable shows up
    bstc_tester i_tester (.tapIn(tapIn), .tdo(tdoOe ? tdo : !tdo));

    initial forever #2 clock = ~clock;

    // Masked comparison, counted
    task automatic compare(input string what, input bstc_note_t n, input logic [63:0] seen);
        checks++;
        if ((seen & n.m) !== n.e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, n.e, seen & n.m);
        end
    endtask : compare
    // Scan result against its note
    task automatic compare_scan(input bstc_note_t n);
        compare("scan", n, i_tester.outQ);
    endtask : compare_scan
    // Channel pins against their note
    task automatic compare_pins(input bstc_note_t n);
        compare("pins", n, {19'h0, busOut.busPos, busOut.busNeg, busOut.busOe, line_out, lineOutOe});
    endtask : compare_pins
    // Note the pin state due from the present inputs; hz floats all
    task automatic expect_pins(input logic hz);
        logic [CHAN_N-1:0] dOe;
        logic [CHAN_N-1:0] rOe;
        dOe = {CHAN_N{drive_on & ~hz}};
        rOe = {CHAN_N{~receive_on_n & ~hz}};
        pinQ.push_back('{m: {19'h0, dOe, dOe, {CHAN_N{1'b1}}, rOe, {CHAN_N{1'b1}}},
            e: {19'h0, dataIn & dOe, ~dataIn & dOe, dOe, busDiff & rOe, rOe}});
        repeat (3) @(negedge clock);
        -> pinTake;
    endtask : expect_pins
    // Scan with a noted expectation
    task automatic scan(input logic ir, input int n, input logic [63:0] din, input logic [63:0] m,
        input logic [63:0] e);
        scanQ.push_back('{m: m, e: e});
        i_tester.scan(ir, n, din);
    endtask : scan
    // Load one opcode, then check chain length and captured cells
    task automatic run_op(input int cfg, input int k, input logic rst);
        logic [63:0] din;
        logic [63:0] cap;
        int len;
        din = {$random(seed), $random(seed)};
        len = (k > 1 || rst) ? 1 : (cfg ? BSR_B_LEN : BSR_A_LEN);
        cap = (len == 1) ? 64'h0 : 64'({receive_on_n, drive_on, 9'h0, dataIn});
        scan(1'b1, IR_W, 64'(opTab[cfg][k]), 64'hff, 64'(IR_CAPTURE));
        if (k == 3) expect_pins(1'b1);
        if (rst) i_tester.tap_reset();
        scan(1'b0, 48, din, (64'h3ff << len) | ((len == 1) ? 64'h1 : 64'h000c01ff),
            (64'(din[9:0]) << len) | cap);
    endtask : run_op
    // Verdict and end of run
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0 && scanQ.size() == 0 && pinQ.size() == 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Watchers take the oldest note whenever a result appears
    initial forever begin
        @(i_tester.done);
        compare_scan(scanQ.pop_front());
    end
    initial forever begin
        @(pinTake);
        compare_pins(pinQ.pop_front());
    end
    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        expect_pins(1'b0);
        // Every enable combination, random data and bus sign
        for (int k = 0; k < 4; k++) begin
            @(negedge clock);
            drive_on = k[0];
            receive_on_n = k[1];
            dataIn = CHAN_N'($random(seed));
            busDiff = CHAN_N'($random(seed));
            expect_pins(1'b0);
        end
        i_tester.tap_reset();
        for (int cfg = 0; cfg < 2; cfg++) begin
            @(negedge clock);
            scan_config_b = cfg[0];
            for (int k = 0; k < 6; k++) run_op(cfg, k, 1'b0);
        end
        run_op(1, 1, 1'b1);
        repeat (20) @(negedge clock);
        print_verdict();
    end
endmodule : tb_top
